/* bench/csg_core_model.sv */
// Core-side model: one final completion per taken tag, no new tag started while stalled
`timescale 1ns/10ps
module csg_core_model (
   input  wire logic       core_clk_i,  // Clock
   input  wire logic       rstn_i,      // Reset, active low
   input  wire logic       take_i,      // Request taken pulse
   input  wire logic [7:0] tag_i,       // Tag of that request
   input  wire logic       stall_i,     // Hold back the start of the next tag
   input  wire logic [11:0] addr_i,     // Start address of that request
   input  wire logic [12:0] len_i,      // Its length in bytes
   input  wire logic       rd_i,        // Memory read
   input  wire logic [7:0] unit_i,      // Completion boundary in bytes
   output logic            cpl_valid_o, // Final completion pulse
   output logic [7:0]      cpl_tag_o    // Its tag
);
   // ****************************************
   // Outstanding tags, answered in order
   // ****************************************
   logic [7:0] q[$];
   int         qs[$];
   int         qe[$];
   int         qu[$];
   int         cur;
   int         fin;
   int         unit;
   int         nxt;
   logic [7:0] tag;
   logic       busy;
   logic       done;
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q = {};
         qs = {};
         qe = {};
         qu = {};
         busy = 1'b0;
         cpl_valid_o <= 1'b0;
         cpl_tag_o   <= 8'h00;
      end else begin
         done = 1'b0;
         if (take_i) begin
            q.push_back(tag_i);
            qs.push_back(int'(addr_i));
            qe.push_back(int'(addr_i) + (rd_i ? int'(len_i) : 1));
            qu.push_back(int'(unit_i));
         end
         if (busy) begin
            // One completion per cycle, cut at the next boundary or at the request's end
            nxt = (cur / unit + 1) * unit;
            cur = (nxt < fin) ? nxt : fin;
            done = (cur == fin);
            busy = !done;
         end else if (!stall_i && q.size() > 0) begin
            tag  = q.pop_front();
            cur  = qs.pop_front();
            fin  = qe.pop_front();
            unit = qu.pop_front();
            busy = 1'b1;
         end
         cpl_valid_o <= done;
         // Idle tag keeps moving so a stale value is never mistaken for a real one
         cpl_tag_o   <= done ? tag : ~cpl_tag_o;
      end
   end
endmodule

/* bench/csg_gate_tb_top.sv */
// Testbench: random and corner requests against the completion space gate
`timescale 1ns/10ps
module csg_gate_tb_top;
   import csg_pkg::*;
   logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rv = 1'b0, stall = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, rdy, ovs, cv, e, fit, f, rd;
   csg_req_t    rq = '0;
   logic [7:0]  tg = 8'h00, rtag = 8'h00, ct;
   logic [15:0] dcmd = 16'h0000, rnd = 16'h0032;
   logic [1:0]  rcbs = 2'b00, rcb_o;
   logic [2:0]  mrrs_o;
   logic [11:0] a;
   logic [12:0] l;
   int          errors = 0, compares = 0, cycles = 0, ho = 0, dd = 0, hn, dn;
   csg_gate dut (.core_clk_i(clk), .rstn_i(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_valid_i(rv), .req_i(rq), .req_tag_i(rtag), .req_ready_o(rdy), .req_oversize_o(ovs),
      .cpl_valid_i(cv), .cpl_tag_i(ct), .cfg_dcommand_i(dcmd), .cfg_rcb_status_i(rcbs),
      .mrrs_o(mrrs_o), .rcb_o(rcb_o));
   csg_core_model core (.core_clk_i(clk), .rstn_i(rstn), .take_i(rdy), .tag_i(rtag), .stall_i(stall),
      .addr_i(rq.addr_lo), .len_i(rq.len_bytes), .rd_i(rq.is_read), .unit_i(rcbs[rq.fn] ? 8'h80 : 8'h40),
      .cpl_valid_o(cv), .cpl_tag_o(ct));
   always #2.5 clk = ~clk;
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic int need(input int ad, input int ln, input int u);
      return (ad % u + ln + u - 1) / u;
   endfunction
   task automatic stop_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Refused requests are held a few cycles and then withdrawn
   task automatic req(input logic [11:0] ad, input logic [12:0] ln, input logic fn, input logic rdq,
                      input logic exp);
      int n;
      @(posedge clk);
      rv <= 1'b1;
      rq <= {ad, ln, fn, rdq};
      rtag <= tg;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 6);
      rv <= 1'b0;
      if (rdy === 1'b1) tg++;
      chk(rdy === exp, "request take");
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(r === 32'h1 && e === 1'b0, "ctrl reset");
      apb(1'b0, 12'h010, 32'h0);
      chk(e === 1'b1, "unmapped");
      for (int c = 0; c < 8; c++) begin
         rnd = lfsr(rnd);
         dcmd <= {rnd[15], 3'(c), rnd[11:0]};
         rcbs <= rnd[13:12];
         repeat (3) @(posedge clk);
         chk(mrrs_o === 3'(c) && rcb_o === rcbs, "status mirror");
      end
      dcmd <= 16'h0000;
      rcbs <= 2'b10;
      stall <= 1'b1;
      repeat (3) @(posedge clk);
      req(12'h000, 13'h0081, 1'b0, 1'b1, 1'b0);
      chk(ovs === 1'b1, "oversize flag");
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         a = rnd[11:0];
         f = rnd[12];
         rd = rnd[15:13] != 3'h0;
         rnd = lfsr(rnd);
         l = 13'(rnd[6:0]) + 13'h0001;
         hn = rd ? need(a, l, f ? 128 : 64) : 1;
         dn = rd ? need(a, l, 16) : 1;
         fit = (ho + hn <= 64) && (dd + dn <= 496);
         req(a, l, f, rd, fit);
         if (fit) begin
            ho += hn;
            dd += dn;
         end
      end
      apb(1'b0, 12'h004, 32'h0);
      chk(r === 32'(ho), "header credits");
      apb(1'b0, 12'h008, 32'h0);
      chk(r === 32'(dd), "data credits");
      stall <= 1'b0;
      repeat (300) @(posedge clk);
      apb(1'b0, 12'h004, 32'h0);
      chk(r === 32'h0, "header released");
      apb(1'b0, 12'h008, 32'h0);
      chk(r === 32'h0, "data released");
      dcmd <= 16'h5000;
      rcbs <= 2'b11;
      stall <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, 12'h00C, 32'h0);
      chk(r[10:8] === 3'h5 && r[2:1] === 2'b11, "status reg");
      req(12'h000, 13'h1000, 1'b0, 1'b1, 1'b1);
      req(12'h000, 13'h1000, 1'b1, 1'b1, 1'b0);
      apb(1'b1, 12'h000, 32'h3);
      req(12'h000, 13'h1000, 1'b1, 1'b1, 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      chk(r === 32'h40, "header full");
      stall <= 1'b0;
      stop_test();
   end
endmodule

/* src/csg_gate.sv */
// Completion space gate: holds non-posted requests until completion space is free
// What this block does
// R1: Reserves 64 completion header credits regardless of payload setting or level.
// R2: Reserves 7936 or 15872 data bytes per performance level.
// R3: Requester issues non-posted requests only when completion space suffices.
// R4: Requester never reads more than programmed maximum read request size.
// R5: Read request size is three bits; codes 0-5 mean 128-4096 bytes; 6-7 reserved.
// R6: Without that field, requester assumes 128 bytes per read.
// R7: Header space covers the worst-case count of completions, not the length.
// R8: First completion starts at request address, ends at end or boundary multiple.
// R9: Last completion ends exactly at start plus length.
// R10: Middle completions are whole multiples of the completion boundary.
// R11: Completion boundary shown as two bits, bit 0 function 0, bit 1 function 1.
// R12: Without that status, requester assumes a 64 byte boundary.
// R13: Boundary bit clear means 64 bytes, four credits; set means 128, eight.
// R14: Outstanding header and data credit counters, raised on issue, lowered on return.
`timescale 1ns/10ps
module csg_gate (
   input  wire logic            core_clk_i,  // 200 MHz user clock
   input  wire logic            rstn_i,      // Async reset, active low
   // APB slave
   input  wire logic            psel,        // Select
   input  wire logic            penable,     // Access phase
   input  wire logic            pwrite,      // Write
   input  wire logic [11:0]     paddr,       // Byte address
   input  wire logic [31:0]     pwdata,      // Write data
   output logic [31:0]          prdata,      // Read data
   output logic                 pready,      // Ready
   output logic                 pslverr,     // Error on unmapped
   // Request side
   input  wire logic            req_valid_i, // Request offered
   input  csg_pkg::csg_req_t    req_i,       // Request fields
   input  wire logic [7:0]      req_tag_i,   // Request tag
   output logic                 req_ready_o, // Request taken
   output logic                 req_oversize_o, // Last offered request: over size limit
   // Completion side
   input  wire logic            cpl_valid_i, // Completion final for its tag
   input  wire logic [7:0]      cpl_tag_i,   // Completed tag
   // Core status
   input  wire logic [15:0]     cfg_dcommand_i,   // Device control
   input  wire logic [1:0]      cfg_rcb_status_i, // Per-function boundary
   output logic [2:0]           mrrs_o,      // Read size field presented
   output logic [1:0]           rcb_o        // Boundary status presented
);
   import csg_pkg::*;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [11:0] ADDR_CTRL   = CSG_ADDR_CTRL;
   localparam logic [11:0] ADDR_HDR    = CSG_ADDR_HDR;
   localparam logic [11:0] ADDR_DAT    = CSG_ADDR_DAT;
   localparam logic [11:0] ADDR_STAT   = CSG_ADDR_STAT;

   function automatic logic [3:0] rcb_credits(input logic bit_v);
      rcb_credits = bit_v ? CSG_RCB_DC_SET : CSG_RCB_DC_CLR; // see R13
   endfunction

   // ****************************************
   // Status capture
   // ****************************************
   logic [2:0] mrrs;
   logic [1:0] rcb;
   logic       perf_high;
   logic       en;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mrrs <= CSG_MRRS_RESET;
         rcb  <= CSG_RCB_RESET;
      end else begin
         mrrs <= cfg_dcommand_i[CSG_MRRS_MSB:CSG_MRRS_LSB]; // see R5
         rcb  <= cfg_rcb_status_i;                          // see R11
      end
   end
   assign mrrs_o = mrrs;
   assign rcb_o  = rcb;

   // ****************************************
   // Credit need
   // ****************************************
   logic [10:0] dat_total;
   wire  [2:0]  mrrs_eff    = (mrrs > CSG_MRRS_MAX_CODE) ? CSG_MRRS_RESET : mrrs; // Reserved -> 128
   wire  [12:0] mrrs_bytes  = 13'(13'h0080 << mrrs_eff);
   wire         rcb_bit     = rcb[req_i.fn];
   wire  [3:0]  rcb_dc      = rcb_credits(rcb_bit);
   wire  [11:0] rcb_mask    = rcb_bit ? 12'h07F : 12'h03F;
   // Worst case: the completer may cut at every boundary the span touches
   wire  [13:0] span_h      = 14'(req_i.addr_lo & rcb_mask) + 14'(req_i.len_bytes);
   wire  [6:0]  need_h_rd   = rcb_bit ? 7'((span_h + 14'h007F) >> 7) : 7'((span_h + 14'h003F) >> 6); // see R7
   wire  [6:0]  need_h      = req_i.is_read ? need_h_rd : 7'h01;
   wire  [13:0] span_d      = 14'(req_i.addr_lo & 12'h00F) + 14'(req_i.len_bytes);
   wire  [10:0] need_d      = req_i.is_read ? 11'((span_d + 14'h000F) >> 4) : 11'h001;
   wire         oversize    = req_i.is_read && (req_i.len_bytes > mrrs_bytes); // see R4
   logic [6:0]  hdr_out;
   logic [10:0] dat_out;
   assign dat_total = perf_high ? CSG_DAT_TOTAL_HIGH : CSG_DAT_TOTAL_GOOD;     // see R2
   wire         fits_h      = ({1'b0, hdr_out} + {1'b0, need_h}) <= {1'b0, CSG_HDR_TOTAL}; // see R1
   wire         fits_d      = ({1'b0, dat_out} + {1'b0, need_d}) <= {1'b0, dat_total};
   // Ready pulse cycle ignores valid, so one offer is charged only once
   wire         grant       = en && req_valid_i && !req_ready_o && !oversize && fits_h && fits_d; // see R3

   // ****************************************
   // Per-tag credit memory and return path
   // ****************************************
   csg_cred_t held_w;
   csg_cred_t held_r;
   logic      ret_pend;
   assign held_w.hdr = need_h;
   assign held_w.dat = need_d;
   csg_tag_mem u_mem (
      .core_clk_i (core_clk_i),
      .we_i       (grant),
      .waddr_i    (req_tag_i),
      .wdata_i    (held_w),
      .raddr_i    (cpl_tag_i),
      .rdata_o    (held_r)
   );
   // Whole-packet release: simple, but holds credits until the tag finishes
   wire [6:0]  next_hdr = 7'(hdr_out + (grant ? need_h : 7'h00) - (ret_pend ? held_r.hdr : 7'h00));
   wire [10:0] next_dat = 11'(dat_out + (grant ? need_d : 11'h000) - (ret_pend ? held_r.dat : 11'h000));
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hdr_out        <= 7'h00;
         dat_out        <= CSG_CNT_RESET;
         ret_pend       <= 1'b0;
         req_ready_o    <= 1'b0;
         req_oversize_o <= 1'b0;
      end else begin
         hdr_out     <= next_hdr; // see R14
         dat_out     <= next_dat; // see R14
         ret_pend    <= cpl_valid_i;
         req_ready_o <= 1'b0;
         if (req_valid_i && !req_ready_o) begin
            req_ready_o    <= grant;
            req_oversize_o <= oversize;
         end
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   // Zero wait: every setup cycle is answered in the next one
   wire        apb_acc = psel && penable;
   wire        hit     = (paddr == ADDR_CTRL) || (paddr == ADDR_HDR) || (paddr == ADDR_DAT) || (paddr == ADDR_STAT);
   wire [31:0] rd_mux  = (paddr == ADDR_CTRL) ? {30'h0, perf_high, en} :
                         (paddr == ADDR_HDR)  ? {25'h0, hdr_out} :
                         (paddr == ADDR_DAT)  ? {21'h0, dat_out} :
                         (paddr == ADDR_STAT) ? {25'h0, rcb_dc, rcb, 1'b0} | {20'h0, 1'b0, mrrs, 8'h00} :
                         32'h0;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         en        <= 1'b1;
         perf_high <= 1'b0;
         prdata    <= 32'h0;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
         end
         if (apb_acc && pready && pwrite && (paddr == ADDR_CTRL)) begin
            en        <= pwdata[0];
            perf_high <= pwdata[1];
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_hdr_limit;
      @(posedge core_clk_i) disable iff (!rstn_i) hdr_out <= CSG_HDR_TOTAL;
   endproperty
   a_hdr_limit: assert property (p_hdr_limit) else $error("header credits exceed space"); // see R1
   property p_dat_limit;
      @(posedge core_clk_i) disable iff (!rstn_i) dat_out <= dat_total;
   endproperty
   a_dat_limit: assert property (p_dat_limit) else $error("data credits exceed space"); // see R2
   property p_no_oversize;
      @(posedge core_clk_i) disable iff (!rstn_i) grant |-> !oversize;
   endproperty
   a_no_oversize: assert property (p_no_oversize) else $error("oversize read granted"); // see R4
   property p_grant_ready;
      @(posedge core_clk_i) disable iff (!rstn_i) (grant && !req_ready_o) |=> req_ready_o;
   endproperty
   a_grant_ready: assert property (p_grant_ready) else $error("grant without ready"); // see R3
   property p_mrrs_track;
      @(posedge core_clk_i) disable iff (!rstn_i) ##1 mrrs_o == $past(cfg_dcommand_i[14:12]);
   endproperty
   a_mrrs_track: assert property (p_mrrs_track) else $error("read size not presented"); // see R5
   property p_rcb_track;
      @(posedge core_clk_i) disable iff (!rstn_i) ##1 rcb_o == $past(cfg_rcb_status_i);
   endproperty
   a_rcb_track: assert property (p_rcb_track) else $error("boundary not presented"); // see R11
   property p_rcb_dc;
      @(posedge core_clk_i) disable iff (!rstn_i) rcb_dc == (rcb_bit ? 4'h8 : 4'h4);
   endproperty
   a_rcb_dc: assert property (p_rcb_dc) else $error("boundary credits wrong"); // see R13
   property p_hdr_up;
      @(posedge core_clk_i) disable iff (!rstn_i) (grant && !cpl_valid_i && !ret_pend) |=> hdr_out == $past(hdr_out) + $past(need_h);
   endproperty
   a_hdr_up: assert property (p_hdr_up) else $error("counter not raised"); // see R14
   property p_dat_up;
      @(posedge core_clk_i) disable iff (!rstn_i) (grant && !ret_pend) |=> dat_out == $past(dat_out) + $past(need_d);
   endproperty
   a_dat_up: assert property (p_dat_up) else $error("data counter not raised"); // see R14
   property p_ret_down;
      @(posedge core_clk_i) disable iff (!rstn_i) (ret_pend && !grant) |=> hdr_out == $past(hdr_out) - $past(held_r.hdr);
   endproperty
   a_ret_down: assert property (p_ret_down) else $error("header counter not lowered"); // see R14
   property p_ready_pulse;
      @(posedge core_clk_i) disable iff (!rstn_i) req_ready_o |=> !req_ready_o;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle"); // see R3
   property p_refuse;
      @(posedge core_clk_i) disable iff (!rstn_i)
         (req_valid_i && !req_ready_o && (oversize || !fits_h || !fits_d)) |=> !req_ready_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("request taken without space"); // see R3
   c_grant: cover property (@(posedge core_clk_i) disable iff (!rstn_i) grant);
   c_full: cover property (@(posedge core_clk_i) disable iff (!rstn_i) req_valid_i && !fits_h);
   c_ret: cover property (@(posedge core_clk_i) disable iff (!rstn_i) ret_pend && grant);
   c_high: cover property (@(posedge core_clk_i) disable iff (!rstn_i) perf_high && grant);
endmodule

/* src/csg_pkg.sv */
// Package: constants and carrier types for the completion space gate
package csg_pkg;
   // ****************************************
   // Completion space
   // ****************************************
   localparam int unsigned CSG_HDR_SPACE        = 64;          // Header credits
   localparam int unsigned CSG_DATA_SPACE_GOOD  = 7936;        // Bytes
   localparam int unsigned CSG_DATA_SPACE_HIGH  = 15872;       // Bytes
   localparam int unsigned CSG_CREDIT_BYTES     = 16;
   localparam logic [6:0]  CSG_HDR_TOTAL        = 7'h40;
   localparam logic [10:0] CSG_DAT_TOTAL_GOOD   = 11'(CSG_DATA_SPACE_GOOD / CSG_CREDIT_BYTES);
   localparam logic [10:0] CSG_DAT_TOTAL_HIGH   = 11'(CSG_DATA_SPACE_HIGH / CSG_CREDIT_BYTES);
   // ****************************************
   // Field layouts and encodings
   // ****************************************
   localparam int unsigned CSG_MRRS_LSB         = 12;
   localparam int unsigned CSG_MRRS_MSB         = 14;
   localparam logic [2:0]  CSG_MRRS_MAX_CODE    = 3'h5;
   localparam logic [2:0]  CSG_MRRS_RESET       = 3'h0;        // 128 bytes
   localparam logic [1:0]  CSG_RCB_RESET        = 2'h0;        // 64 bytes
   localparam logic [8:0]  CSG_MRRS_BASE_DC     = 9'h008;      // 128 B in credits
   localparam logic [3:0]  CSG_RCB_DC_CLR       = 4'h4;        // 64 B
   localparam logic [3:0]  CSG_RCB_DC_SET       = 4'h8;        // 128 B
   localparam logic [10:0] CSG_CNT_RESET        = 11'h000;
   localparam logic [11:0] CSG_ADDR_CTRL        = 12'h000;     // Enable, performance level
   localparam logic [11:0] CSG_ADDR_HDR         = 12'h004;     // Header credits out
   localparam logic [11:0] CSG_ADDR_DAT         = 12'h008;     // Data credits out
   localparam logic [11:0] CSG_ADDR_STAT        = 12'h00C;     // Boundary and read size
   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [11:0] addr_lo;   // Low start address bits
      logic [12:0] len_bytes; // Requested length
      logic        fn;        // Physical function
      logic        is_read;   // Memory read (else no data back)
   } csg_req_t;
   typedef struct packed {
      logic [6:0]  hdr;
      logic [10:0] dat;
   } csg_cred_t;
endpackage

/* src/csg_tag_mem.sv */
// Small memory of credits held per outstanding tag
`timescale 1ns/10ps
module csg_tag_mem (
   input  wire logic             core_clk_i, // Clock
   input  wire logic             we_i,       // Write enable
   input  wire logic [7:0]       waddr_i,    // Write tag
   input  csg_pkg::csg_cred_t    wdata_i,    // Credits to hold
   input  wire logic [7:0]       raddr_i,    // Read tag
   output csg_pkg::csg_cred_t    rdata_o     // Registered read data
);
   import csg_pkg::*;
   csg_cred_t mem [0:255];
   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule
